// *** logic/ais_pkg.sv ***
// package: register map, field layout and codes of the input select block
package ais_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // register byte offsets
    localparam logic [3:0] OFS_CHAN0_SEL = 4'h0;
    localparam logic [3:0] OFS_SCAN_SEL = 4'h4;
    localparam logic [3:0] OFS_AMP_CTRL = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    // ========================================
    // reset values
    localparam logic [4:0] RST_CHAN0_SEL = 5'h00;
    localparam logic [15:0] RST_SCAN_SEL = 16'h0000;
    localparam logic [3:0] RST_AMP_CTRL = 4'h0;

    // ========================================
    // control register field positions
    localparam int AMP1_EN_BIT = 0;
    localparam int AMP3_EN_BIT = 1;
    localparam int CMP_EN_BIT = 2;
    localparam int SCAN_EN_BIT = 3;

    // status register field positions
    localparam int ST_PTR_LSB = 0;
    localparam int ST_CODE_LSB = 4;
    localparam int ST_SCAN_BIT = 9;
    localparam int ST_LOW_REFERENCE_VOLTAGE_BIT = 10;
    localparam int ST_OPEN_BIT = 11;
    localparam int ST_TEMP_BIT = 12;
    localparam int ST_AMP_BIT = 13;
    localparam int ST_REPURP_BIT = 14;

    // ========================================
    // positive input select codes
    localparam logic [4:0] CODE_PIN_LAST = 5'h0F;
    localparam logic [4:0] CODE_AMP1 = 5'h18;
    localparam logic [4:0] CODE_AMP3 = 5'h1A;
    localparam logic [4:0] CODE_TEMP = 5'h1E;
    localparam logic [4:0] CODE_OPEN = 5'h1F;

    // pins shared with the amplifier outputs
    localparam logic [3:0] AMP1_PIN = 4'h3;
    localparam logic [3:0] AMP3_PIN = 4'h6;

    // highest pin that comparator or op amp use can take over
    localparam logic [3:0] REPURP_LAST_PIN = 4'h7;

    // bonded analog inputs of this part; absent ones sample low reference
    localparam logic [15:0] PINS_PRESENT = 16'h1FFF;

    // scan engine states
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN = 2'b10
    } ais_scan_e;

endpackage : ais_pkg

// *** logic/ais_route_dec.sv ***
// module: decode of a positive input code into analog switch controls
module ais_route_dec
    import ais_pkg::*;
(
    // selection
    input wire logic [4:0] i_code,
    input wire logic i_amp1_en,
    input wire logic i_amp3_en,
    input wire logic i_cmp_en,
    // routing
    output logic [15:0] o_pin,
    output logic o_amp1,
    output logic o_amp3,
    output logic o_temp,
    output logic o_open,
    output logic o_low_reference_voltage,
    output logic o_repurp
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] pin_idx;
    logic is_pin;
    logic amp1_pin;
    logic amp3_pin;

    // op amp codes fall back to the shared pin when the amp is off
    always_comb
    begin
        is_pin = (i_code <= CODE_PIN_LAST);
        pin_idx = i_code[3:0];
        amp1_pin = (i_code == CODE_AMP1) && !i_amp1_en;
        amp3_pin = (i_code == CODE_AMP3) && !i_amp3_en;
        if (amp1_pin)
        begin
            pin_idx = AMP1_PIN;
        end
        else if (amp3_pin)
        begin
            pin_idx = AMP3_PIN;
        end
        is_pin = is_pin || amp1_pin || amp3_pin;
    end

    // one switch per analog pin; absent pins never close
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_pin
            assign o_pin[gi] = is_pin && (pin_idx == 4'(gi)) && PINS_PRESENT[gi];
        end
    endgenerate

    assign o_amp1 = (i_code == CODE_AMP1) && i_amp1_en;
    assign o_amp3 = (i_code == CODE_AMP3) && i_amp3_en;
    assign o_temp = (i_code == CODE_TEMP);
    assign o_open = (i_code == CODE_OPEN);
    // a selected pin that is not bonded samples the low reference
    assign o_low_reference_voltage = is_pin && !PINS_PRESENT[pin_idx];
    // low pins mean the repurposed analog signals while cmp/amp is on
    assign o_repurp = is_pin && (pin_idx <= REPURP_LAST_PIN)
        && (i_cmp_en || i_amp1_en || i_amp3_en);

endmodule : ais_route_dec

// *** logic/ais_input_select.sv ***
// module: converter input select and scan control with Avalon-MM registers
module ais_input_select
    import ais_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // converter handshake
    input wire logic i_conv_done,
    // analog switch controls
    output logic [15:0] o_pin_sel,
    output logic o_amp1_sel,
    output logic o_amp3_sel,
    output logic o_temp_sel,
    output logic o_open_sel,
    output logic o_low_reference_voltage_sel,
    output logic o_repurposed,
    output logic o_scan_active
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // registers
    logic [4:0] chan0_sel_q;
    logic [15:0] scan_bits_q;
    logic [3:0] ctrl_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [3:0] ptr_q;
    logic [3:0] ptr_d;
    ais_scan_e state_q;
    ais_scan_e state_d;

    // decoded bus strobes
    logic wr_go;
    logic rd_take;
    logic scan_want;

    // routing from the decoder
    logic [4:0] code_eff;
    logic [15:0] dec_pin;
    logic dec_amp1;
    logic dec_amp3;
    logic dec_temp;
    logic dec_open;
    logic dec_low_reference_voltage;
    logic dec_repurp;

    // ========================================
    // bus handshake
    // a write lands only at the edge where waitrequest is seen low
    assign wr_go = i_avs_write && !wait_q;
    // read data is captured one edge early so it stands with wait low
    assign rd_take = i_avs_read && wait_q;

    // waitrequest drops for one cycle after each request is seen
    // a request still high after its answer edge counts as a new one
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wait_q <= 1'b1;
        end
        else if ((i_avs_read || i_avs_write) && wait_q)
        begin
            wait_q <= 1'b0;
        end
        else
        begin
            wait_q <= 1'b1;
        end
    end

    assign o_avs_waitrequest = wait_q;

    // ========================================
    // software registers
    // reserved select codes are stored as written and left to decode
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            chan0_sel_q <= RST_CHAN0_SEL;
        end
        else if (wr_go && (i_avs_address == OFS_CHAN0_SEL))
        begin
            chan0_sel_q <= i_avs_writedata[4:0];
        end
    end

    // every scan bit is writable even for pins this part lacks
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            scan_bits_q <= RST_SCAN_SEL;
        end
        else if (wr_go && (i_avs_address == OFS_SCAN_SEL))
        begin
            scan_bits_q <= i_avs_writedata[15:0];
        end
    end

    // amplifier, comparator and scan enables
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_q <= RST_AMP_CTRL;
        end
        else if (wr_go && (i_avs_address == OFS_AMP_CTRL))
        begin
            ctrl_q <= i_avs_writedata[3:0];
        end
    end

    // ========================================
    // read path
    // unmapped offsets read zero and writes to them are dropped
    // status flags are a snapshot of the registered outputs, one edge behind decode; pointer and code fields are live
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            rdata_q <= 32'h0000_0000;
            case (i_avs_address)
                OFS_CHAN0_SEL: rdata_q[4:0] <= chan0_sel_q;
                OFS_SCAN_SEL: rdata_q[15:0] <= scan_bits_q;
                OFS_AMP_CTRL: rdata_q[3:0] <= ctrl_q;
                OFS_STATUS:
                begin
                    rdata_q[ST_PTR_LSB +: 4] <= ptr_q;
                    rdata_q[ST_CODE_LSB +: 5] <= code_eff;
                    rdata_q[ST_SCAN_BIT] <= o_scan_active;
                    rdata_q[ST_LOW_REFERENCE_VOLTAGE_BIT] <= o_low_reference_voltage_sel;
                    rdata_q[ST_OPEN_BIT] <= o_open_sel;
                    rdata_q[ST_TEMP_BIT] <= o_temp_sel;
                    rdata_q[ST_AMP_BIT] <= o_amp1_sel || o_amp3_sel;
                    rdata_q[ST_REPURP_BIT] <= o_repurposed;
                end
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign o_avs_readdata = rdata_q;

    // ========================================
    // scan engine
    // the next included input after the pointer, wrapping past 15
    function automatic logic [3:0] next_incl(input logic [15:0] bits,
                                             input logic [3:0] cur);
        logic [3:0] idx;
        logic found;
        idx = cur;
        found = 1'b0;
        for (int k = 1; k <= 16; k++)
        begin
            if (!found && bits[4'(cur + 4'(k))])
            begin
                idx = 4'(cur + 4'(k));
                found = 1'b1;
            end
        end
        return idx;
    endfunction : next_incl

    // with no bit set there is nothing to scan, so manual select rules
    assign scan_want = ctrl_q[SCAN_EN_BIT] && (scan_bits_q != 16'h0000);

    // scan state and pointer advance
    always_comb
    begin
        state_d = state_q;
        ptr_d = ptr_q;
        case (state_q)
            SCAN_IDLE:
            begin
                if (scan_want)
                begin
                    state_d = SCAN_RUN;
                    // start at the lowest included input
                    ptr_d = next_incl(scan_bits_q, 4'hF);
                end
            end
            SCAN_RUN:
            begin
                if (!scan_want)
                begin
                    state_d = SCAN_IDLE;
                end
                else if (i_conv_done || !scan_bits_q[ptr_q])
                begin
                    // skip a bit cleared while it was the current one
                    ptr_d = next_incl(scan_bits_q, ptr_q);
                end
            end
            default:
            begin
                state_d = SCAN_IDLE;
            end
        endcase
    end

    // scan state; a done pulse while idle has no effect
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= SCAN_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // scan pointer; it only moves while running or on the start edge
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ptr_q <= 4'h0;
        end
        else
        begin
            ptr_q <= ptr_d;
        end
    end

    // ========================================
    // routing
    // scan position x selects analog input x directly
    // the effective code is also what the status register reports
    always_comb
    begin
        if (state_q == SCAN_RUN)
        begin
            code_eff = {1'b0, ptr_q};
        end
        else
        begin
            code_eff = chan0_sel_q;
        end
    end

    ais_route_dec u_dec (
        .i_code(code_eff),
        .i_amp1_en(ctrl_q[AMP1_EN_BIT]),
        .i_amp3_en(ctrl_q[AMP3_EN_BIT]),
        .i_cmp_en(ctrl_q[CMP_EN_BIT]),
        .o_pin(dec_pin),
        .o_amp1(dec_amp1),
        .o_amp3(dec_amp3),
        .o_temp(dec_temp),
        .o_open(dec_open),
        .o_low_reference_voltage(dec_low_reference_voltage),
        .o_repurp(dec_repurp)
    );

    // switch controls are registered so the analog side sees no glitches
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pin_sel <= 16'h0000;
        end
        else
        begin
            o_pin_sel <= dec_pin;
        end
    end

    // non-pin sources; at most one of them is decoded at a time
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_amp1_sel <= 1'b0;
            o_amp3_sel <= 1'b0;
            o_temp_sel <= 1'b0;
            o_open_sel <= 1'b0;
        end
        else
        begin
            o_amp1_sel <= dec_amp1;
            o_amp3_sel <= dec_amp3;
            o_temp_sel <= dec_temp;
            o_open_sel <= dec_open;
        end
    end

    // flags for software and the sampling stage
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_low_reference_voltage_sel <= 1'b0;
            o_repurposed <= 1'b0;
        end
        else
        begin
            o_low_reference_voltage_sel <= dec_low_reference_voltage;
            o_repurposed <= dec_repurp;
        end
    end

    // scan activity follows the state one edge later, like the switches
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_scan_active <= 1'b0;
        end
        else
        begin
            o_scan_active <= (state_q == SCAN_RUN);
        end
    end

endmodule : ais_input_select

// *** dv/ais_conv_model.sv ***
// converter model: answers each scanned input after a fixed sampling delay
module ais_conv_model #(
    parameter int DELAY = 3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // scan handshake
    input wire logic i_active,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    // ========================================
    // one done pulse per conversion; stands still while scan is idle
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 8'h00;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (!i_active)
                cnt_q <= 8'h00;
            else if (cnt_q == 8'(DELAY))
            begin
                cnt_q <= 8'h00;
                o_done <= 1'b1;
            end
            else
                cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : ais_conv_model

// *** dv/ais_properties.sv ***
// checker: routing exclusivity, bus answer and scan hold of the select block
module ais_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bus and scan
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic i_conv_done,
    input wire logic o_scan_active,
    // switch controls
    input wire logic [15:0] o_pin_sel,
    input wire logic o_amp1_sel,
    input wire logic o_amp3_sel,
    input wire logic o_temp_sel,
    input wire logic o_open_sel,
    input wire logic o_low_reference_voltage_sel,
    input wire logic o_repurposed
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ========================================
    // named steps of a bus access and a quiet scan cycle
    sequence req_s;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence ans_s;
        ##1 !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    sequence quiet_s;
        o_scan_active && !i_conv_done && !i_avs_write;
    endsequence
    // ========================================
    // at most one pin switch closes; each single source is checked against the pins and at most one other source
    pin_onehot_a: assert property ($onehot0(o_pin_sel))
        else $error("more than one pin switch closed");
    open_alone_a: assert property (o_open_sel |-> o_pin_sel == 16'h0000 && !o_temp_sel)
        else $error("open input with a source routed");
    temp_alone_a: assert property (o_temp_sel |-> o_pin_sel == 16'h0000 && !o_amp3_sel)
        else $error("diode routed with another source");
    amp1_alone_a: assert property (o_amp1_sel |-> o_pin_sel == 16'h0000 && !o_amp3_sel)
        else $error("amp 1 routed with another source");
    amp3_alone_a: assert property (o_amp3_sel |-> o_pin_sel == 16'h0000 && !o_low_reference_voltage_sel)
        else $error("amp 3 routed with another source");
    low_reference_voltage_alone_a: assert property (o_low_reference_voltage_sel |-> o_pin_sel == 16'h0000)
        else $error("low reference with a pin switch closed");
    repurp_low_a: assert property (o_repurposed |-> o_pin_sel[15:8] == 8'h00)
        else $error("upper pin flagged as repurposed");
    bus_answer_a: assert property (req_s |-> ans_s)
        else $error("bus answer not one wait cycle");
    // a write lands one edge before the pointer reacts, so three quiet edges
    scan_hold_a: assert property (quiet_s ##1 quiet_s ##1 quiet_s |=> $stable(o_pin_sel))
        else $error("scan input moved without done");
endmodule : ais_properties

bind ais_input_select ais_properties u_props (.i_clk, .i_rst, .i_avs_read, .i_avs_write,
    .o_avs_waitrequest, .i_conv_done, .o_scan_active, .o_pin_sel, .o_amp1_sel, .o_amp3_sel,
    .o_temp_sel, .o_open_sel, .o_low_reference_voltage_sel, .o_repurposed);

// *** dv/testbench.sv ***
// testbench: register access, routing codes and scan of the select block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ais_pkg::*;
    // ========================================
    // stimulus and observed signals
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata, q;
    logic [15:0] pins;
    logic waitreq, done, scan, amp1, amp3, temp, open, low_reference_voltage, repurp;
    int fail_count = 0;
    int n_checks = 0;
    initial forever #20 i_clk = ~i_clk;
    ais_input_select u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_conv_done(done), .o_pin_sel(pins),
        .o_amp1_sel(amp1), .o_amp3_sel(amp3), .o_temp_sel(temp), .o_open_sel(open),
        .o_low_reference_voltage_sel(low_reference_voltage), .o_repurposed(repurp), .o_scan_active(scan));
    ais_conv_model u_conv (.i_clk(i_clk), .i_rst(i_rst), .i_active(scan), .o_done(done));
    // ========================================
    // report and compare
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit
    // one access; holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge i_clk); while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // routing outputs as one word, pins above the five single switches
    function automatic logic [31:0] out_v();
        return {11'h000, pins, amp1, amp3, temp, open, low_reference_voltage};
    endfunction : out_v
    function automatic logic [31:0] pv(input int p);
        return 32'h20 << p;
    endfunction : pv
    // outputs follow a register one edge after the write lands
    task automatic sel(input logic [4:0] c, input logic [31:0] exp);
        bus(1'b1, OFS_CHAN0_SEL, {27'h0, c});
        @(posedge i_clk);
        @(negedge i_clk);
        chk(out_v(), exp);
    endtask : sel
    // ========================================
    // scenarios
    task automatic t_regs;
        @(negedge i_clk);
        chk(out_v(), pv(0));
        bus(1'b0, OFS_SCAN_SEL, 32'h0);
        chk(q, 32'h0000);
        bus(1'b1, OFS_SCAN_SEL, 32'hFFFFFFFF);
        bus(1'b0, OFS_SCAN_SEL, 32'h0);
        chk(q, 32'h0000FFFF);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFS_SCAN_SEL, 32'h0);
    endtask : t_regs
    task automatic t_pins;
        for (int c = 0; c < 16; c++)
            sel(5'(c), (c < 13) ? pv(c) : 32'h01);
    endtask : t_pins
    task automatic t_codes;
        sel(CODE_OPEN, 32'h02);
        sel(CODE_TEMP, 32'h04);
        bus(1'b0, OFS_CHAN0_SEL, 32'h0);
        chk(q, {27'h0, CODE_TEMP});
        sel(5'h10, 32'h00);
        bus(1'b1, OFS_AMP_CTRL, 32'h1);
        sel(CODE_AMP1, 32'h10);
        sel(CODE_AMP3, pv(6));
        bus(1'b1, OFS_AMP_CTRL, 32'h2);
        sel(CODE_AMP3, 32'h08);
        sel(CODE_AMP1, pv(3));
    endtask : t_codes
    // pins 0 to 7 count as repurposed only while the comparator or an op amp is on
    task automatic t_repurp;
        bus(1'b1, OFS_AMP_CTRL, 32'h4);
        sel(5'h07, pv(7));
        chk_bit(repurp, 1'b1);
        sel(5'h08, pv(8));
        chk_bit(repurp, 1'b0);
        bus(1'b1, OFS_AMP_CTRL, 32'h1);
        sel(5'h02, pv(2));
        chk_bit(repurp, 1'b1);
        bus(1'b1, OFS_AMP_CTRL, 32'h0);
        sel(5'h05, pv(5));
        chk_bit(repurp, 1'b0);
    endtask : t_repurp
    // scan of inputs 0, 2, 4 and absent 13, then wrap to 0
    task automatic t_scan;
        logic [31:0] exp [5];
        logic [31:0] prev;
        exp = '{pv(0), pv(2), pv(4), 32'h01, pv(0)};
        sel(CODE_OPEN, 32'h02);
        bus(1'b1, OFS_AMP_CTRL, 32'h8);
        repeat (4) @(posedge i_clk);
        chk_bit(scan, 1'b0);
        bus(1'b1, OFS_SCAN_SEL, 32'h2015);
        for (int i = 0; i < 5; i++)
        begin
            prev = out_v();
            do @(negedge i_clk); while (out_v() === prev);
            chk(out_v(), exp[i]);
        end
        chk_bit(scan, 1'b1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk_bit(q[ST_SCAN_BIT], 1'b1);
    endtask : t_scan
    // reset in mid-scan stops the scan and clears every register
    task automatic t_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk(out_v(), 32'h0);
        chk_bit(scan, 1'b0);
        @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(out_v(), pv(0));
        bus(1'b0, OFS_SCAN_SEL, 32'h0);
        chk(q, 32'h0000);
    endtask : t_reset
    // ========================================
    // main sequence and watchdog
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_regs();
        t_pins();
        t_codes();
        t_repurp();
        t_scan();
        t_reset();
        close_out();
    end
    initial
    begin
        #2000000;
        fail_count++;
        close_out();
    end
endmodule : testbench
